// ### prc_config_bank.sv
// Primary rail configuration bank: two read-only programmed registers,
// the switch, fault and overcurrent logic they steer, and an AHB-Lite slave.
// Assumes one 100 MHz clock and inputs synchronous to it.
//
// Notes on behaviour
// [RQ1] Seven-bit low-power buck voltage in bits 0-6
// [RQ2] Bit 0 closes bias switch in low-power
// [RQ3] Linear regulator driving rail: switch always open
// [RQ4] Bit 1: overcurrent timeout 10 ms or 1 ms
// [RQ5] Bit 2: linear output 3.3 V or 5 V
// [RQ6] Bit 3: overcurrent threshold 150 or 75 mA
// [RQ7] Thermal fault disables rail, bit 4 fail-safe
// [RQ8] Overvoltage disables rail, bit 5 fail-safe
// [RQ9] Bit 6: monitor input 3.3 V or 5 V
// [RQ10] Bit 7 keeps switch closed in all modes; the code opens it while the linear regulator drives the rail
// [RQ11] Always-closed switch only with 5 V normal rail
// [RQ12] Both registers clear on power-on reset
// [RQ13] Bit 7 of voltage register reads zero
// [RQ14] Both registers read-only, writes ignored
//
// Register access over AHB-Lite and the placing of the registers were chosen for this implementation.
`include "prc_defs.svh"

module prc_config_bank #(
  parameter int unsigned OC_LONG_CYC  =
    `PRC_OC_TO_LONG_MS * `PRC_US_PER_MS * `PRC_CLK_MHZ,
  parameter int unsigned OC_SHORT_CYC =
    `PRC_OC_TO_SHORT_MS * `PRC_US_PER_MS * `PRC_CLK_MHZ
) (
  input  wire logic        clk_i,
  input  wire logic        nrst_i,
  // AHB-Lite slave
  input  wire logic        hsel_i,
  input  wire logic [31:0] haddr_i,
  input  wire logic [1:0]  htrans_i,
  input  wire logic        hwrite_i,
  input  wire logic [2:0]  hsize_i,
  input  wire logic [31:0] hwdata_i,
  input  wire logic        hready_i,
  output logic      [31:0] hrdata_o,
  output logic             hreadyout_o,
  output logic             hresp_o,
  // Programmed values from the fuse array
  input  wire logic        otp_load_i,
  input  wire logic [7:0]  otp_voltage_i,
  input  wire logic [7:0]  otp_protection_i,
  // Regulator status
  input  wire logic        rail_ldo_i,
  input  wire logic        low_power_on_mode_i,
  input  wire logic        normal_5v_i,
  input  wire logic        thermal_shutdown_i,
  input  wire logic        overvoltage_i,
  input  wire logic        ldo_overcurrent_i,
  // Regulator control
  output logic      [6:0]  low_power_on_mode_buck_voltage_sel_o,
  output logic             ldo_voltage_sel_o,
  output logic             ldo_overcurrent_threshold_sel_o,
  output logic             monitor_input_voltage_sel_o,
  output logic             bypass_switch_closed_o,
  output logic             pnp_protect_o,
  output logic             rail_disable_o,
  output logic             failsafe_req_o,
  output logic             irq_o
);

  // ********************************
  // Helpers
  // ********************************

  // Word index of a byte address
  function automatic logic [2:0] prc_idx(input logic [31:0] a);
    prc_idx = a[4:2];
  endfunction

  // Read value of a register index
  function automatic logic [31:0] prc_rd(input prc_pkg::prc_state_s st,
                                         input logic [2:0]          ix);
    prc_rd = `PRC_WORD_0;
    case (ix)
      `PRC_OFS_LPV:   prc_rd[7:0] = st.cfg_lpv;
      `PRC_OFS_PROT:  prc_rd[7:0] = st.cfg_prot;
      `PRC_OFS_STAT:  prc_rd[`PRC_EV_W-1:0] = st.stat;
      `PRC_OFS_MASK:  prc_rd[`PRC_EV_W-1:0] = st.mask;
      `PRC_OFS_STATE: prc_rd[5:0] = {st.rail, st.oc_trip, st.sw_close,
                                     st.safe, st.rail_off};
      default:        prc_rd = `PRC_WORD_0;  // Unmapped reads zero
    endcase
  endfunction

  // ********************************
  // State
  // ********************************
  prc_pkg::prc_state_s   s;        // Registered state
  prc_pkg::prc_state_s   next_s;   // Its next value
  logic                  acc;      // Address phase taken
  logic                  alw_ok;   // Always-closed allowed now
  logic                  cfg_bad;  // Forbidden switch setting
  logic                  to_safe;  // Fault asks for fail-safe
  logic                  fault;    // Any rail fault
  logic [`PRC_CNT_W-1:0] lim;      // Selected timeout in cycles
  logic [`PRC_EV_W-1:0]  ev;       // Events this cycle

  // ********************************
  // Next state
  // ********************************

  // All behaviour in one place; outputs other than hresp_o come from the struct flops
  always_comb begin
    next_s = s;
    ev     = `PRC_EV_RST;
    acc    = hsel_i & hready_i & htrans_i[1];

    // Fuse transfer; bit 7 of the voltage register forced low
    if (otp_load_i) begin
      next_s.cfg_lpv  = {1'b0, otp_voltage_i[`PRC_LPV_MSB:0]};  // see [RQ1] see [RQ13]
      next_s.cfg_prot = otp_protection_i;
    end

    // Always-closed only honoured with a 5 V normal rail
    alw_ok  = s.cfg_prot[`PRC_B_SW_ALW] & normal_5v_i;   // see [RQ11]
    cfg_bad = s.cfg_prot[`PRC_B_SW_ALW] & ~normal_5v_i;  // see [RQ11]
    ev[`PRC_EV_CFGERR] = cfg_bad;

    // Bias switch
    if (rail_ldo_i) begin
      next_s.sw_close = 1'b0;                              // see [RQ3]
    end else if (alw_ok) begin
      next_s.sw_close = 1'b1;                              // see [RQ10]
    end else if (low_power_on_mode_i) begin
      next_s.sw_close = s.cfg_prot[`PRC_B_SW_LP];          // see [RQ2]
    end else begin
      next_s.sw_close = 1'b0;                              // see [RQ10]
    end

    // Overcurrent timer, only while the linear regulator drives
    lim = s.cfg_prot[`PRC_B_OC_TO] ? `PRC_CNT_W'(OC_SHORT_CYC)
                                   : `PRC_CNT_W'(OC_LONG_CYC);  // see [RQ4]
    if (!(ldo_overcurrent_i && rail_ldo_i)) begin
      // Condition gone: release protection and restart count
      next_s.oc_cnt  = '0;
      next_s.oc_trip = 1'b0;
    end else if (!s.oc_trip) begin
      if (s.oc_cnt >= lim - `PRC_CNT_W'(1)) begin
        next_s.oc_trip       = 1'b1;                       // see [RQ4]
        ev[`PRC_EV_OCTO]     = 1'b1;
      end else begin
        next_s.oc_cnt = s.oc_cnt + `PRC_CNT_W'(1);
      end
    end

    // Fault reaction
    fault   = thermal_shutdown_i | overvoltage_i;
    to_safe = (thermal_shutdown_i & s.cfg_prot[`PRC_B_THERM]) |  // see [RQ7]
              (overvoltage_i & s.cfg_prot[`PRC_B_OVOLT]);        // see [RQ8]
    ev[`PRC_EV_THERM] = thermal_shutdown_i;
    ev[`PRC_EV_OVOLT] = overvoltage_i;
    case (s.rail)
      prc_pkg::PRC_RAIL_ON: begin
        // Any fault stops the rail; selection picks fail-safe
        if (fault) begin
          next_s.rail_off = 1'b1;                          // see [RQ7] see [RQ8]
          next_s.rail     = to_safe ? prc_pkg::PRC_RAIL_SAFE
                                    : prc_pkg::PRC_RAIL_OFF;
          next_s.safe     = to_safe;
        end
      end
      prc_pkg::PRC_RAIL_OFF: begin
        // A later fault still escalates when selected
        if (to_safe) begin
          next_s.rail = prc_pkg::PRC_RAIL_SAFE;
          next_s.safe = 1'b1;
        end
      end
      prc_pkg::PRC_RAIL_SAFE: begin
        // Only a reset leaves fail-safe
        next_s.rail = prc_pkg::PRC_RAIL_SAFE;
      end
      default: begin
        next_s.rail = prc_pkg::PRC_RAIL_ON;
      end
    endcase

    // Bus data phase: only the mask accepts data
    if (s.dph_wr && s.dph_idx == `PRC_OFS_MASK) begin
      next_s.mask = hwdata_i[`PRC_EV_W-1:0];
    end
    // Writes to the programmed registers fall through here unused  // see [RQ14]

    // Bus address phase; zero wait, read data ready at data phase
    next_s.dph_wr  = acc & hwrite_i;
    next_s.dph_idx = prc_idx(haddr_i);
    next_s.hready  = 1'b1;
    if (acc && !hwrite_i) begin
      next_s.hrdata = prc_rd(s, prc_idx(haddr_i));
      if (prc_idx(haddr_i) == `PRC_OFS_STAT) begin
        next_s.stat = `PRC_EV_RST;  // Read clears
      end
    end

    // New events after the clear, so a set wins
    next_s.stat = next_s.stat | ev;
    next_s.irq  = |(next_s.stat & next_s.mask);
  end

  // ********************************
  // Registers
  // ********************************

  // Everything except the ready flag clears on power-on reset; hready is set
  always_ff @(posedge clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      s          <= '0;                                    // see [RQ12]
      s.cfg_lpv  <= `PRC_CFG_RST;                          // see [RQ12]
      s.cfg_prot <= `PRC_CFG_RST;                          // see [RQ12]
      s.rail     <= prc_pkg::PRC_RAIL_ON;
      s.hready   <= 1'b1;
    end else begin
      s <= next_s;
    end
  end

  // ********************************
  // Outputs
  // ********************************

  // Field outputs go to the analogue trims as they stand
  assign low_power_on_mode_buck_voltage_sel_o         = s.cfg_lpv[`PRC_LPV_MSB:0];   // see [RQ1]
  assign ldo_voltage_sel_o               = s.cfg_prot[`PRC_B_LDO_V];   // see [RQ5]
  assign ldo_overcurrent_threshold_sel_o = s.cfg_prot[`PRC_B_OC_THR];  // see [RQ6]
  assign monitor_input_voltage_sel_o     = s.cfg_prot[`PRC_B_MON_V];   // see [RQ9]
  assign bypass_switch_closed_o          = s.sw_close;
  assign pnp_protect_o                   = s.oc_trip;
  assign rail_disable_o                  = s.rail_off;
  assign failsafe_req_o                  = s.safe;
  assign irq_o                           = s.irq;
  assign hrdata_o                        = s.hrdata;
  assign hreadyout_o                     = s.hready;
  assign hresp_o                         = `PRC_RESP_OKAY;

  // ********************************
  // Assertions
  // ********************************
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (!nrst_i);

  AST_LPV_TOP_ZERO: assert property (s.cfg_lpv[7] == 1'b0)  // see [RQ13]
    else $error("voltage register bit 7 set");

  AST_RESET_CLEAR: assert property (                        // see [RQ12]
    $past(!nrst_i) |-> (s.cfg_lpv == `PRC_CFG_RST && s.cfg_prot == `PRC_CFG_RST))
    else $error("config not cleared by reset");

  AST_SW_LDO_OPEN: assert property (rail_ldo_i |=> !bypass_switch_closed_o)  // see [RQ3]
    else $error("switch closed with linear regulator");

  AST_SW_LP: assert property (                              // see [RQ2]
    (!rail_ldo_i && low_power_on_mode_i && !s.cfg_prot[`PRC_B_SW_ALW])
    |=> bypass_switch_closed_o == $past(s.cfg_prot[`PRC_B_SW_LP]))
    else $error("low-power switch not per bit 0");

  AST_SW_ALWAYS: assert property (                          // see [RQ10]
    (!rail_ldo_i && s.cfg_prot[`PRC_B_SW_ALW] && normal_5v_i) |=> bypass_switch_closed_o)
    else $error("always-closed switch open");

  AST_SW_FORBIDDEN: assert property (                       // see [RQ11]
    (!rail_ldo_i && !low_power_on_mode_i && !normal_5v_i)
    |=> (!bypass_switch_closed_o &&
         (s.stat[`PRC_EV_CFGERR] || !$past(s.cfg_prot[`PRC_B_SW_ALW]))))
    else $error("switch closed in normal mode without 5 V");

  AST_OC_TIME: assert property (                            // see [RQ4]
    $rose(pnp_protect_o) |-> $past(s.oc_cnt) == $past(lim) - `PRC_CNT_W'(1))
    else $error("overcurrent timeout length wrong");

  AST_THERM_REACT: assert property (                        // see [RQ7]
    (s.rail == prc_pkg::PRC_RAIL_ON && thermal_shutdown_i && !overvoltage_i)
    |=> rail_disable_o && (failsafe_req_o == $past(s.cfg_prot[`PRC_B_THERM])))
    else $error("thermal reaction wrong");

  AST_OVOLT_REACT: assert property (                        // see [RQ8]
    (s.rail == prc_pkg::PRC_RAIL_ON && overvoltage_i && !thermal_shutdown_i)
    |=> rail_disable_o && (failsafe_req_o == $past(s.cfg_prot[`PRC_B_OVOLT])))
    else $error("overvoltage reaction wrong");

  AST_RO_WRITE: assert property (                           // see [RQ14]
    (s.dph_wr && !otp_load_i) |=> $stable(s.cfg_lpv) && $stable(s.cfg_prot))
    else $error("programmed register changed by a write");

  COV_THERM_SAFE: cover property (s.rail == prc_pkg::PRC_RAIL_ON ##1
                                  s.rail == prc_pkg::PRC_RAIL_SAFE);
  COV_OC_TRIP:    cover property ($rose(pnp_protect_o));
  COV_STAT_CLR:   cover property (irq_o ##1 !irq_o);
  COV_LPV_5V:     cover property (low_power_on_mode_buck_voltage_sel_o == `PRC_LPV_5V0);

endmodule

// ### prc_defs.svh
// Constants of the primary rail configuration bank: word indices, fields, codes, times.
// Assumes inclusion by bare name from the package and the bank module.
`ifndef PRC_DEFS_SVH
`define PRC_DEFS_SVH

// ********************************
// Clock and timeouts
// ********************************
`define PRC_CLK_MHZ        100
`define PRC_OC_TO_LONG_MS  10
`define PRC_OC_TO_SHORT_MS 1
`define PRC_US_PER_MS      1000
`define PRC_CNT_W          20

// ********************************
// Register word indices
// ********************************
`define PRC_OFS_LPV   3'h0
`define PRC_OFS_PROT  3'h1
`define PRC_OFS_STAT  3'h2
`define PRC_OFS_MASK  3'h3
`define PRC_OFS_STATE 3'h4

// ********************************
// Protection register fields
// ********************************
`define PRC_B_SW_LP   0
`define PRC_B_OC_TO   1
`define PRC_B_LDO_V   2
`define PRC_B_OC_THR  3
`define PRC_B_THERM   4
`define PRC_B_OVOLT   5
`define PRC_B_MON_V   6
`define PRC_B_SW_ALW  7

// ********************************
// Voltage field, codes and resets
// ********************************
`define PRC_LPV_MSB   6
`define PRC_LPV_3V3   7'h32
`define PRC_LPV_5V0   7'h54
`define PRC_CFG_RST   8'h00
`define PRC_EV_RST    4'h0

// ********************************
// Event bits, bus codes
// ********************************
`define PRC_EV_THERM  0
`define PRC_EV_OVOLT  1
`define PRC_EV_OCTO   2
`define PRC_EV_CFGERR 3
`define PRC_EV_W      4
`define PRC_RESP_OKAY 1'h0
`define PRC_WORD_0    32'h0000_0000

`endif

// ### prc_pkg.sv
// Types shared by the primary rail configuration bank.
// Assumes prc_defs.svh is on the include path.
`include "prc_defs.svh"

package prc_pkg;

  // ********************************
  // Rail state
  // ********************************
  typedef enum logic [1:0] {
    PRC_RAIL_ON   = 2'b00,  // Regulator running
    PRC_RAIL_OFF  = 2'b01,  // Disabled by a fault, device keeps going
    PRC_RAIL_SAFE = 2'b10   // Disabled and device in fail-safe
  } prc_rail_e;

  // ********************************
  // Whole state of the bank
  // ********************************
  typedef struct packed {
    logic [7:0]            cfg_lpv;   // Low-power voltage register
    logic [7:0]            cfg_prot;  // Protection register
    logic [`PRC_EV_W-1:0]  stat;      // Sticky events
    logic [`PRC_EV_W-1:0]  mask;      // Interrupt enables
    prc_rail_e             rail;      // Rail state
    logic [`PRC_CNT_W-1:0] oc_cnt;    // Overcurrent duration
    logic                  oc_trip;   // Pass transistor protection
    logic                  sw_close;  // Bias switch drive
    logic                  rail_off;  // Rail disable drive
    logic                  safe;      // Fail-safe request
    logic                  irq;       // Interrupt drive
    logic                  dph_wr;    // Write data phase pending
    logic [2:0]            dph_idx;   // Its register index
    logic [31:0]           hrdata;    // Read data
    logic                  hready;    // Ready out
  } prc_state_s;

endpackage

// ### tb_primary_rail_otp_config.sv
// Self-checking bench for the primary rail configuration bank.
// Assumes prc_defs.svh, prc_pkg.sv and prc_config_bank.sv compile first.
module tb_primary_rail_otp_config;
  timeunit 1ns;
  timeprecision 1ps;
  // ********************************
  // Signals
  // ********************************
  localparam int OC_L = 20;            // Shortened long timeout
  localparam int OC_S = 4;             // Shortened short timeout
  typedef struct {logic [31:0] exp; bit rd;} prc_note_s;
  logic        clk_i = 1'b0;
  logic        nrst_i = 1'b0;          // Reset held from time zero
  logic        hsel_i = 1'b0;
  logic [31:0] haddr_i = 32'h0;
  logic [1:0]  htrans_i = 2'h0;
  logic        hwrite_i = 1'b0;
  logic [2:0]  hsize_i = 3'h2;         // Whole words only
  logic [31:0] hwdata_i = 32'h0;
  logic        otp_load_i = 1'b0;
  logic [7:0]  otp_voltage_i = 8'h0;
  logic [7:0]  otp_protection_i = 8'h0;
  logic        rail_ldo_i = 1'b0;
  logic        low_power_on_mode_i = 1'b0;
  logic        normal_5v_i = 1'b0;
  logic        thermal_shutdown_i = 1'b0;
  logic        overvoltage_i = 1'b0;
  logic        ldo_overcurrent_i = 1'b0;
  logic [31:0] hrdata_o;
  logic        hreadyout_o, hresp_o, ldo_v, oc_thr, mon_v, sw, pnp, rdis, fsafe, irq_o;
  logic [6:0]  low_power_on_mode;
  logic [15:0] outs;                   // All control outputs in one word
  logic [31:0] last_rd;                // Read data seen by the master
  prc_note_s   notes[$];               // Expected results, oldest first
  event        obs_ev;                 // A result is ready to compare
  int          fails = 0;
  int          comparisons = 0;
  int          cycles = 0;
  int          seed = 32'heed3bc51;
  logic [7:0]  v, p;
  logic        swx;
  assign outs = {hresp_o, irq_o, fsafe, rdis, pnp, sw, mon_v, oc_thr, ldo_v, low_power_on_mode};
  prc_config_bank #(.OC_LONG_CYC(OC_L), .OC_SHORT_CYC(OC_S)) u_dut (
    .clk_i(clk_i), .nrst_i(nrst_i), .hsel_i(hsel_i), .haddr_i(haddr_i),
    .htrans_i(htrans_i), .hwrite_i(hwrite_i), .hsize_i(hsize_i), .hwdata_i(hwdata_i),
    .hready_i(hreadyout_o), .hrdata_o(hrdata_o), .hreadyout_o(hreadyout_o),
    .hresp_o(hresp_o), .otp_load_i(otp_load_i), .otp_voltage_i(otp_voltage_i),
    .otp_protection_i(otp_protection_i), .rail_ldo_i(rail_ldo_i),
    .low_power_on_mode_i(low_power_on_mode_i), .normal_5v_i(normal_5v_i),
    .thermal_shutdown_i(thermal_shutdown_i), .overvoltage_i(overvoltage_i),
    .ldo_overcurrent_i(ldo_overcurrent_i), .low_power_on_mode_buck_voltage_sel_o(low_power_on_mode),
    .ldo_voltage_sel_o(ldo_v), .ldo_overcurrent_threshold_sel_o(oc_thr),
    .monitor_input_voltage_sel_o(mon_v), .bypass_switch_closed_o(sw),
    .pnp_protect_o(pnp), .rail_disable_o(rdis), .failsafe_req_o(fsafe), .irq_o(irq_o));
  // ********************************
  // Clock, timeout and verdict
  // ********************************
  always #5 clk_i = ~clk_i;
  // Whole run needs about 790 cycles; the ceiling leaves ample margin
  always @(posedge clk_i) begin
    cycles++;
    if (cycles == 4000) begin
      fails++;
      give_verdict();
    end
  end
  task automatic give_verdict();
    $display("comparisons %0d fails %0d", comparisons, fails);
    if (fails == 0 && comparisons > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask
  // ********************************
  // Compare tasks and result monitor
  // ********************************
  task automatic cmp_rd(input logic [31:0] e, input logic [31:0] g);
    comparisons++;
    if (g !== e) begin
      fails++;
      $display("MISMATCH read data exp %h got %h", e, g);
    end
  endtask
  task automatic cmp_out(input logic [15:0] e, input logic [15:0] g);
    comparisons++;
    if (g !== e) begin
      fails++;
      $display("MISMATCH control outputs exp %h got %h", e, g);
    end
  endtask
  // Monitor takes the oldest note whenever a result is announced
  initial forever begin
    prc_note_s n;
    @(obs_ev);
    n = notes.pop_front();
    if (n.rd) cmp_rd(n.exp, last_rd);
    else cmp_out(n.exp[15:0], outs);
  end
  // ********************************
  // Drivers
  // ********************************
  function automatic logic [15:0] mk(logic i, logic f, logic d, logic o, logic s,
                                     logic [7:0] pr, logic [7:0] vo);
    return {1'b0, i, f, d, o, s, pr[6], pr[3], pr[2], vo[6:0]};
  endfunction
  task automatic step(input int n);
    repeat (n) @(posedge clk_i);
  endtask
  // Outputs are sampled mid-cycle so edge updates have landed
  task automatic chk(input logic [15:0] e);
    @(negedge clk_i);
    notes.push_back('{{16'h0, e}, 1'b0});
    ->obs_ev;
  endtask
  // Single AHB-Lite transfer; read data taken at the data-phase edge
  task automatic bus(input logic w, input logic [31:0] a, input logic [31:0] d,
                     input logic [31:0] e);
    @(posedge clk_i);
    hsel_i <= 1'b1;
    htrans_i <= 2'h2;
    haddr_i <= a;
    hwrite_i <= w;
    do @(posedge clk_i); while (hreadyout_o !== 1'b1);
    hsel_i <= 1'b0;
    htrans_i <= 2'h0;
    hwdata_i <= d;
    do @(posedge clk_i); while (hreadyout_o !== 1'b1);
    if (!w) begin
      last_rd = hrdata_o;
      notes.push_back('{e, 1'b1});
      ->obs_ev;
    end
  endtask
  task automatic load(input logic [7:0] vo, input logic [7:0] pr);
    @(posedge clk_i);
    otp_load_i <= 1'b1;
    otp_voltage_i <= vo;
    otp_protection_i <= pr;
    @(posedge clk_i);
    otp_load_i <= 1'b0;
    step(3);
  endtask
  task automatic rst();
    @(posedge clk_i);
    nrst_i <= 1'b0;
    {rail_ldo_i, low_power_on_mode_i, normal_5v_i} <= 3'h0;
    {thermal_shutdown_i, overvoltage_i, ldo_overcurrent_i} <= 3'h0;
    step(16);
    nrst_i <= 1'b1;
  endtask
  // ********************************
  // Main sequence
  // ********************************
  initial begin
    rst();
    chk(16'h0);
    bus(1'b0, 32'h0, 32'h0, 32'h0);
    bus(1'b0, 32'h4, 32'h0, 32'h0);
    // Every switch input combination with random protection images, voltage images fixed or random
    for (int k = 0; k < 32; k++) begin
      v = (k % 4 == 0) ? 8'hB2 : (k % 4 == 1) ? 8'hD4 : 8'($random(seed));
      p = 8'($random(seed));
      p[0] = k[2];
      p[7] = k[3];
      load(v, p);
      rail_ldo_i <= k[4];
      low_power_on_mode_i <= k[0];
      normal_5v_i <= k[1];
      swx = !k[4] && ((p[7] && k[1]) || (k[0] && p[0]));
      step(3);
      chk(mk(1'b0, 1'b0, 1'b0, 1'b0, swx, p, v));
      bus(1'b1, k[0] ? 32'h0 : 32'h4, 32'($random(seed)), 32'h0);
      bus(1'b0, 32'h0, 32'h0, {25'h0, v[6:0]});
      bus(1'b0, 32'h4, 32'h0, {24'h0, p});
    end
    bus(1'b0, 32'h18, 32'h0, 32'h0);                  // Unmapped place reads zero
    // Overcurrent timeout for both settings of the select bit
    for (int k = 0; k < 2; k++) begin
      rst();
      chk(16'h0);
      p = {6'h0, k[0], 1'b0};
      load(8'h0, p);
      rail_ldo_i <= 1'b1;
      ldo_overcurrent_i <= 1'b1;
      step((k ? OC_S : OC_L) - 1);
      chk(mk(1'b0, 1'b0, 1'b0, 1'b0, 1'b0, p, 8'h0));
      step(3);
      chk(mk(1'b0, 1'b0, 1'b0, 1'b1, 1'b0, p, 8'h0));
      ldo_overcurrent_i <= 1'b0;
      step(3);
      chk(mk(1'b0, 1'b0, 1'b0, 1'b0, 1'b0, p, 8'h0));
    end
    // Thermal and overvoltage faults, reaction bit clear and set, masked and not
    for (int k = 0; k < 4; k++) begin
      rst();
      p = 8'($random(seed));
      p[7] = 1'b0;
      p[4 + k % 2] = k[1];
      load(8'h0, p);
      bus(1'b1, 32'hC, k[1] ? 32'hF : 32'h0, 32'h0);
      if (k[0]) overvoltage_i <= 1'b1;
      else thermal_shutdown_i <= 1'b1;
      step(3);
      chk(mk(k[1], k[1], 1'b1, 1'b0, 1'b0, p, 8'h0));
      {thermal_shutdown_i, overvoltage_i} <= 2'h0;
      step(2);
      bus(1'b0, 32'h8, 32'h0, 32'h1 << k[0]);
      step(2);
      chk(mk(1'b0, k[1], 1'b1, 1'b0, 1'b0, p, 8'h0));
    end
    step(2);
    give_verdict();
  end
endmodule
